// ### shared/cssb_regs.svh
// Purpose: offsets, reset values and codes of the status bank
// Assumes: register indices are printed offsets; byte address = 4 * index
// Notes: definitions only
`ifndef CSSB_REGS_SVH
`define CSSB_REGS_SVH

`define CSSB_IDX_W            10
`define CSSB_IDX_TRANS_LO     10'h120
`define CSSB_IDX_TRANS_HI     10'h121
`define CSSB_IDX_LATCH_LO     10'h122
`define CSSB_IDX_LATCH_HI     10'h123
`define CSSB_IDX_FALLBACK     10'h124
`define CSSB_IDX_PLL_SW       10'h125
`define CSSB_IDX_SYS_LO       10'h126
`define CSSB_IDX_SYS_HI       10'h127
`define CSSB_IDX_REVISION     10'h128
`define CSSB_IDX_PART_LO      10'h12a
`define CSSB_IDX_PART_HI      10'h12b
`define CSSB_IDX_QUEUE        10'h12c
`define CSSB_IDX_VC           10'h12d

`define CSSB_RESP_OKAY        2'h0
`define CSSB_RESP_SLVERR      2'h2

`define CSSB_CLK_ERR_RESET    16'h0000
`define CSSB_SYS_ERR_RESET    16'h0000
`define CSSB_FB_CODE_INITIAL  3'h7

`endif

// ### shared/cssb_pkg.sv
// Purpose: types shared by the status bank and its bench
// Assumes: nothing beyond the constants header
// Notes: fallback code values mirror the fallback state machine outside
package cssb_pkg;

    typedef logic [2:0] cssb_fb_code_t;
    typedef logic [1:0] cssb_dpll_lock_t;
    typedef enum logic [3:0] {
        CSSB_VC_PAUSE,
        CSSB_VC_START
    } cssb_vc_state_t;

endpackage : cssb_pkg

// ### rtl/cssb_status_bank.sv
// Purpose: clock and system error / status register bank behind an AXI4-Lite slave
// Assumes: every status source runs on aclk; commands and frame_sync are one-cycle pulses
// Notes: each byte register occupies one aligned word, data in bits 7:0
`timescale 1ns/1ps
`default_nettype none
`include "cssb_regs.svh"

module cssb_status_bank #(
    parameter int                ADDR_W        = 12,
    parameter logic [7:0]        REVISION_CODE = 8'h5a,   // arbitrary value
    parameter logic [15:0]       PART_CODE     = 16'hc3a5 // arbitrary value
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // clock watchdogs: bit 15 failsafe ref .. bit 0 frame a
    input  wire logic [15:0]            watchdog_live_err,
    input  wire logic [15:0]            watchdog_enable,
    output logic [15:0]                 latched_clock_err,
    // fallback machine
    input  wire logic                   in_fallback_flag,
    input  wire cssb_pkg::cssb_fb_code_t fallback_state_code,
    input  wire logic                   active_set_flag,
    input  wire logic                   go_cmd,
    input  wire logic                   clear_cmd,
    input  wire logic                   force_cmd,
    input  wire logic                   frame_sync,
    output logic                        go_take,
    output logic                        clear_take,
    output logic                        force_take,
    // plls and memories
    input  wire logic                   analog_pll_unlock_raw,
    input  wire logic                   unlock_threshold_flag,
    input  wire cssb_pkg::cssb_dpll_lock_t first_dpll_lock_code,
    input  wire cssb_pkg::cssb_dpll_lock_t second_dpll_lock_code,
    input  wire logic                   conn_mem_reset_flag,
    input  wire logic                   active_data_page_flag,
    // system error events: bit 15 failsafe .. bit 0 event_notice_queue overflow
    input  wire logic [15:0]            system_err_event,
    // pci target queues
    input  wire logic                   bridge_queue_full,
    input  wire logic                   vc_queue_full,
    input  wire logic                   data_mem_queue_full,
    // virtual channel switching
    input  wire logic                   vc_pause_cmd,
    input  wire logic                   vc_start_cmd,
    output cssb_pkg::cssb_vc_state_t    vc_switching_state
);


    // status state

    logic [15:0]               transient_r;
    logic [15:0]               latched_r;
    logic [15:0]               sys_err_r;
    logic                      go_pending_flag_r;
    logic                      clear_pending_flag_r;
    logic                      force_pending_flag_r;
    logic                      pause_pending_flag_r;
    logic                      start_pending_flag_r;
    cssb_pkg::cssb_vc_state_t  vc_state_r;
    cssb_pkg::cssb_vc_state_t  vc_state_nxt;


    // bus state

    logic                      aw_have_r;
    logic                      w_have_r;
    logic [`CSSB_IDX_W-1:0]    aw_idx_r;
    logic [7:0]                wbyte_r;
    logic                      wlane_r;
    logic                      bvalid_r;
    logic [1:0]                bresp_r;
    logic                      rvalid_r;
    logic [1:0]                rresp_r;
    logic [31:0]               rdata_r;


    // write path decode

    wire                       aw_fire  = s_axi_awvalid & s_axi_awready;
    wire                       w_fire   = s_axi_wvalid & s_axi_wready;
    wire                       wr_do    = aw_have_r & w_have_r & ~bvalid_r;
    wire [7:0]                 wr_ones  = wlane_r ? wbyte_r : 8'h00;
    wire                       wr_t_lo  = wr_do & (aw_idx_r == `CSSB_IDX_TRANS_LO);
    wire                       wr_t_hi  = wr_do & (aw_idx_r == `CSSB_IDX_TRANS_HI);
    wire                       wr_l_lo  = wr_do & (aw_idx_r == `CSSB_IDX_LATCH_LO);
    wire                       wr_l_hi  = wr_do & (aw_idx_r == `CSSB_IDX_LATCH_HI);
    wire                       wr_s_lo  = wr_do & (aw_idx_r == `CSSB_IDX_SYS_LO);
    wire                       wr_s_hi  = wr_do & (aw_idx_r == `CSSB_IDX_SYS_HI);
    wire [15:0]                clr_trans = {wr_t_hi ? wr_ones : 8'h00, wr_t_lo ? wr_ones : 8'h00};
    wire [15:0]                clr_latch = {wr_l_hi ? wr_ones : 8'h00, wr_l_lo ? wr_ones : 8'h00};
    wire [15:0]                clr_sys   = {wr_s_hi ? wr_ones : 8'h00, wr_s_lo ? wr_ones : 8'h00};
    wire                       aw_mapped = idx_mapped(aw_idx_r);


    // status sources

    // live result gated by enable; bit order fixed by the watchdog port
    wire [15:0]                transient_now = watchdog_live_err & watchdog_enable;

    function automatic logic idx_mapped(input logic [`CSSB_IDX_W-1:0] idx);
        idx_mapped = (idx >= `CSSB_IDX_TRANS_LO && idx <= `CSSB_IDX_REVISION) ||
                     (idx >= `CSSB_IDX_PART_LO && idx <= `CSSB_IDX_VC);
    endfunction : idx_mapped


    // read path decode

    wire                       ar_fire = s_axi_arvalid & s_axi_arready;
    wire [`CSSB_IDX_W-1:0]     ar_idx  = s_axi_araddr[`CSSB_IDX_W+1:2];
    wire                       ar_mapped = idx_mapped(ar_idx);

    wire [7:0] rd_fallback = {in_fallback_flag,
                              fallback_state_code,
                              active_set_flag,
                              go_pending_flag_r,
                              clear_pending_flag_r,
                              force_pending_flag_r};
    wire [7:0] rd_pll_sw   = {analog_pll_unlock_raw,
                              unlock_threshold_flag,
                              first_dpll_lock_code,
                              second_dpll_lock_code,
                              conn_mem_reset_flag,
                              active_data_page_flag};
    wire [7:0] rd_queue    = {5'h00,
                              bridge_queue_full,
                              vc_queue_full,
                              data_mem_queue_full};
    wire [7:0] rd_vc       = {2'h0,
                              pause_pending_flag_r,
                              start_pending_flag_r,
                              vc_state_r};

    logic [7:0] rd_byte;
    always_comb begin
        case (ar_idx)
            `CSSB_IDX_TRANS_LO: rd_byte = transient_r[7:0];
            `CSSB_IDX_TRANS_HI: rd_byte = transient_r[15:8];
            `CSSB_IDX_LATCH_LO: rd_byte = latched_r[7:0];
            `CSSB_IDX_LATCH_HI: rd_byte = latched_r[15:8];
            `CSSB_IDX_FALLBACK: rd_byte = rd_fallback;
            `CSSB_IDX_PLL_SW:   rd_byte = rd_pll_sw;
            `CSSB_IDX_SYS_LO:   rd_byte = sys_err_r[7:0];
            `CSSB_IDX_SYS_HI:   rd_byte = sys_err_r[15:8];
            `CSSB_IDX_REVISION: rd_byte = REVISION_CODE;
            `CSSB_IDX_PART_LO:  rd_byte = PART_CODE[7:0];
            `CSSB_IDX_PART_HI:  rd_byte = PART_CODE[15:8];
            `CSSB_IDX_QUEUE:    rd_byte = rd_queue;
            `CSSB_IDX_VC:       rd_byte = rd_vc;
            default:            rd_byte = 8'h00;
        endcase
    end


    // error registers

    // transient is a live copy; a clear write has no effect on it, even for one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transient_r <= `CSSB_CLK_ERR_RESET;
        end else begin
            transient_r <= transient_now & ~(clr_trans & ~transient_now);
        end
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latched_r <= `CSSB_CLK_ERR_RESET;
        end else begin
            latched_r <= (latched_r & ~clr_latch) | transient_now;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_err_r <= `CSSB_SYS_ERR_RESET;
        end else begin
            sys_err_r <= (sys_err_r & ~clr_sys) | system_err_event;
        end
    end

    assign latched_clock_err = latched_r;


    // pending commands, resolved at frame sync

    // a command arriving on the frame edge itself waits for the next frame
    assign go_take    = go_pending_flag_r & frame_sync;
    assign clear_take = clear_pending_flag_r & frame_sync;
    assign force_take = force_pending_flag_r & frame_sync;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_pending_flag_r    <= 1'b0;
            clear_pending_flag_r <= 1'b0;
            force_pending_flag_r <= 1'b0;
        end else begin
            go_pending_flag_r    <= go_cmd    | (go_pending_flag_r & ~frame_sync);
            clear_pending_flag_r <= clear_cmd | (clear_pending_flag_r & ~frame_sync);
            force_pending_flag_r <= force_cmd | (force_pending_flag_r & ~frame_sync);
        end
    end

    // latest command cancels the opposite pending one
    always_comb begin
        vc_state_nxt = vc_state_r;
        if (frame_sync) begin
            case (vc_state_r)
                cssb_pkg::CSSB_VC_PAUSE: if (start_pending_flag_r) vc_state_nxt = cssb_pkg::CSSB_VC_START;
                cssb_pkg::CSSB_VC_START: if (pause_pending_flag_r) vc_state_nxt = cssb_pkg::CSSB_VC_PAUSE;
                default:                 vc_state_nxt = cssb_pkg::CSSB_VC_PAUSE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_pending_flag_r <= 1'b0;
            start_pending_flag_r <= 1'b0;
            vc_state_r           <= cssb_pkg::CSSB_VC_PAUSE;
        end else begin
            pause_pending_flag_r <= vc_pause_cmd |
                                    (pause_pending_flag_r & ~frame_sync & ~vc_start_cmd);
            start_pending_flag_r <= vc_start_cmd |
                                    (start_pending_flag_r & ~frame_sync & ~vc_pause_cmd);
            vc_state_r           <= vc_state_nxt;
        end
    end

    assign vc_switching_state = vc_state_r;


    // axi4-lite write channel
    // one byte per word: only wdata[7:0] and wstrb[0] matter

    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready  = ~w_have_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_idx_r  <= '0;
            wbyte_r   <= 8'h00;
            wlane_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CSSB_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_have_r <= 1'b1;
                aw_idx_r  <= s_axi_awaddr[`CSSB_IDX_W+1:2];
            end
            if (w_fire) begin
                w_have_r <= 1'b1;
                wbyte_r  <= s_axi_wdata[7:0];
                wlane_r  <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= aw_mapped ? `CSSB_RESP_OKAY : `CSSB_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end


    // axi4-lite read channel
    // arready stays low while rvalid stands: one read at a time

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // snapshot at acceptance keeps rdata stable while the master stalls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= `CSSB_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= ar_mapped ? `CSSB_RESP_OKAY : `CSSB_RESP_SLVERR;
            rdata_r  <= {24'h00_0000, rd_byte};
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : cssb_status_bank

`default_nettype wire

// ### tb/cssb_status_bank_properties.sv
// Purpose: port-level checks of the clock and system status bank
// Assumes: one aclk domain, synchronous active-low reset
// Notes: attached to every bank instance by the bind at the foot
`timescale 1ns/1ps
`default_nettype none

module cssb_status_bank_checker (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire logic                     s_axi_bvalid,
    input wire logic [15:0]              watchdog_live_err,
    input wire logic [15:0]              watchdog_enable,
    input wire logic [15:0]              latched_clock_err,
    input wire logic                     go_cmd,
    input wire logic                     force_cmd,
    input wire logic                     frame_sync,
    input wire logic                     go_take,
    input wire logic                     clear_take,
    input wire logic                     force_take,
    input wire logic                     vc_start_cmd,
    input wire logic                     vc_pause_cmd,
    input wire cssb_pkg::cssb_vc_state_t vc_switching_state
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [15:0] live_on = watchdog_live_err & watchdog_enable;

    property p_latch_set;
        |live_on |=> (latched_clock_err & $past(live_on)) == $past(live_on);
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latched bit missed a live error");
    // a clear can only land on the edge where the write response rises
    property p_latch_hold;
        $past(aresetn) && !$rose(s_axi_bvalid) |-> (~latched_clock_err & $past(latched_clock_err)) == 16'h0;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched bit dropped without a write");
    property p_latch_src;
        $past(aresetn) |-> (latched_clock_err & ~$past(latched_clock_err) & ~$past(live_on)) == 16'h0;
    endproperty
    a_latch_src: assert property (p_latch_src) else $error("latched bit set from a disabled source");
    property p_take_frame;
        go_take || clear_take || force_take |-> frame_sync;
    endproperty
    a_take_frame: assert property (p_take_frame) else $error("command taken outside frame sync");
    property p_go_frame;
        go_cmd && !frame_sync ##1 frame_sync |-> go_take;
    endproperty
    a_go_frame: assert property (p_go_frame) else $error("pending go not taken at frame");
    property p_force_frame;
        force_cmd && !frame_sync ##1 frame_sync |-> force_take;
    endproperty
    a_force_frame: assert property (p_force_frame) else $error("pending force not taken at frame");
    property p_vc_start;
        vc_start_cmd && !vc_pause_cmd && !frame_sync ##1 frame_sync && !vc_pause_cmd
            |=> vc_switching_state == cssb_pkg::CSSB_VC_START;
    endproperty
    a_vc_start: assert property (p_vc_start) else $error("start did not take effect at frame");
    property p_vc_hold;
        $past(aresetn) && !$past(frame_sync) |-> $stable(vc_switching_state);
    endproperty
    a_vc_hold: assert property (p_vc_hold) else $error("switching state moved between frames");

    c_take: cover property (go_take && clear_take && force_take);
    c_clear: cover property ($rose(s_axi_bvalid) && latched_clock_err != 16'h0);
    c_vc: cover property (vc_switching_state == cssb_pkg::CSSB_VC_START);
endmodule : cssb_status_bank_checker

bind cssb_status_bank cssb_status_bank_checker chk_i (
    .aclk, .aresetn, .s_axi_bvalid, .watchdog_live_err, .watchdog_enable, .latched_clock_err,
    .go_cmd, .force_cmd, .frame_sync, .go_take, .clear_take, .force_take, .vc_start_cmd,
    .vc_pause_cmd, .vc_switching_state
);

`default_nettype wire

// ### tb/cssb_status_bank_tb.sv
// Purpose: directed register-level test of the status bank
// Assumes: inputs change on aclk edges by non-blocking assignment
// Notes: prot is held constant
`timescale 1ns/1ps
`default_nettype none
`include "cssb_regs.svh"

module cssb_status_bank_tb;
    localparam logic [7:0]  REV  = 8'h3c;    // arbitrary value
    localparam logic [15:0] PART = 16'h9e17; // arbitrary value
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] watchdog_live_err = 16'h0, watchdog_enable = 16'h0, system_err_event = 16'h0, latched_clock_err;
    logic in_fallback_flag = 1'b0, active_set_flag = 1'b0, frame_sync = 1'b0;
    logic go_cmd = 1'b0, clear_cmd = 1'b0, force_cmd = 1'b0, go_take, clear_take, force_take;
    cssb_pkg::cssb_fb_code_t fallback_state_code = 3'h7;
    cssb_pkg::cssb_dpll_lock_t first_dpll_lock_code = 2'h0, second_dpll_lock_code = 2'h0;
    logic analog_pll_unlock_raw = 1'b0, unlock_threshold_flag = 1'b0, conn_mem_reset_flag = 1'b0;
    logic active_data_page_flag = 1'b0, bridge_queue_full = 1'b0, vc_queue_full = 1'b0, data_mem_queue_full = 1'b0;
    logic vc_pause_cmd = 1'b0, vc_start_cmd = 1'b0;
    cssb_pkg::cssb_vc_state_t vc_switching_state;
    logic [15:0] lat_m = 16'h0, sys_m = 16'h0;
    logic [2:0] pend_m = 3'h0;
    logic pp_m = 1'b0, sp_m = 1'b0;
    logic [3:0] vc_m = 4'h0;
    int failures = 0;
    int compares = 0;

    cssb_status_bank #(.ADDR_W(12), .REVISION_CODE(REV), .PART_CODE(PART)) cssb_status_bank_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .watchdog_live_err, .watchdog_enable, .latched_clock_err,
        .in_fallback_flag, .fallback_state_code, .active_set_flag, .go_cmd, .clear_cmd, .force_cmd,
        .frame_sync, .go_take, .clear_take, .force_take, .analog_pll_unlock_raw, .unlock_threshold_flag,
        .first_dpll_lock_code, .second_dpll_lock_code, .conn_mem_reset_flag, .active_data_page_flag,
        .system_err_event, .bridge_queue_full, .vc_queue_full, .data_mem_queue_full, .vc_pause_cmd,
        .vc_start_cmd, .vc_switching_state
    );

    initial begin
        forever #50 aclk = ~aclk;
    end

    task automatic test_done();
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // a wait that ran out ends the run at once
    task automatic bound(input int n);
        if (n >= 40) begin
            chk(32'h0, 32'h1);
            test_done();
        end
    endtask : bound

    // {response, byte} the bank should return, from the current stimulus
    function automatic logic [9:0] expect_of(input logic [9:0] idx);
        logic [15:0] tr;
        tr = watchdog_live_err & watchdog_enable;
        case (idx)
            `CSSB_IDX_TRANS_LO: return {2'h0, tr[7:0]};
            `CSSB_IDX_TRANS_HI: return {2'h0, tr[15:8]};
            `CSSB_IDX_LATCH_LO: return {2'h0, lat_m[7:0]};
            `CSSB_IDX_LATCH_HI: return {2'h0, lat_m[15:8]};
            `CSSB_IDX_FALLBACK: return {2'h0, in_fallback_flag, fallback_state_code, active_set_flag, pend_m};
            `CSSB_IDX_PLL_SW: return {2'h0, analog_pll_unlock_raw, unlock_threshold_flag, first_dpll_lock_code,
                                      second_dpll_lock_code, conn_mem_reset_flag, active_data_page_flag};
            `CSSB_IDX_SYS_LO: return {2'h0, sys_m[7:0]};
            `CSSB_IDX_SYS_HI: return {2'h0, sys_m[15:8]};
            `CSSB_IDX_REVISION: return {2'h0, REV};
            `CSSB_IDX_PART_LO: return {2'h0, PART[7:0]};
            `CSSB_IDX_PART_HI: return {2'h0, PART[15:8]};
            `CSSB_IDX_QUEUE: return {2'h0, 5'h0, bridge_queue_full, vc_queue_full, data_mem_queue_full};
            `CSSB_IDX_VC: return {2'h0, 2'h0, pp_m, sp_m, vc_m};
            default: return {`CSSB_RESP_SLVERR, 8'h0};
        endcase
    endfunction : expect_of

    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && n < 40);
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        bound(n);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [9:0] idx);
        logic [9:0] e;
        int n;
        e = expect_of(idx);
        n = 0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 40);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'b0;
        bound(n);
        chk({30'h0, s_axi_rresp}, {30'h0, e[9:8]});
        if (e[9:8] === `CSSB_RESP_OKAY) chk(s_axi_rdata, {24'h0, e[7:0]});
        @(posedge aclk);
    endtask : rd

    task automatic rd_all();
        for (int i = 32'h120; i <= 32'h12e; i++) begin
            rd(i[9:0]);
        end
    endtask : rd_all

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_all();
        for (int i = 0; i < 7; i++) begin
            fallback_state_code <= (i == 6) ? 3'h7 : 3'(i);
            in_fallback_flag <= (i != 6);
            active_set_flag <= i[0];
            {analog_pll_unlock_raw, unlock_threshold_flag, conn_mem_reset_flag, active_data_page_flag} <= 4'(i + 5);
            first_dpll_lock_code <= 2'(i % 3);
            second_dpll_lock_code <= 2'((i + 1) % 3);
            {bridge_queue_full, vc_queue_full, data_mem_queue_full} <= i[2:0];
            repeat (2) @(posedge aclk);
            rd(`CSSB_IDX_FALLBACK);
            rd(`CSSB_IDX_PLL_SW);
            rd(`CSSB_IDX_QUEUE);
        end
        // live errors on enabled and disabled sources in both bytes
        watchdog_live_err <= 16'ha5c3;
        watchdog_enable <= 16'h0ff0;
        lat_m = 16'ha5c3 & 16'h0ff0;
        repeat (2) @(posedge aclk);
        rd_all();
        chk({16'h0, latched_clock_err}, {16'h0, lat_m});
        wr(`CSSB_IDX_LATCH_HI, 8'hff, `CSSB_RESP_OKAY);
        rd(`CSSB_IDX_LATCH_HI);
        watchdog_live_err <= 16'h0;
        repeat (2) @(posedge aclk);
        rd(`CSSB_IDX_TRANS_LO);
        rd(`CSSB_IDX_LATCH_LO);
        wr(`CSSB_IDX_LATCH_LO, 8'h40, `CSSB_RESP_OKAY);
        wr(`CSSB_IDX_LATCH_HI, 8'hff, `CSSB_RESP_OKAY);
        wr(`CSSB_IDX_FALLBACK, 8'hff, `CSSB_RESP_OKAY);
        wr(10'h129, 8'hff, `CSSB_RESP_SLVERR);
        lat_m = lat_m & 16'h00bf;
        rd_all();
        chk({16'h0, latched_clock_err}, {16'h0, lat_m});
        system_err_event <= 16'h8142;
        @(posedge aclk);
        system_err_event <= 16'h0;
        sys_m = 16'h8142;
        repeat (2) @(posedge aclk);
        rd(`CSSB_IDX_SYS_LO);
        rd(`CSSB_IDX_SYS_HI);
        wr(`CSSB_IDX_SYS_LO, 8'h02, `CSSB_RESP_OKAY);
        wr(`CSSB_IDX_SYS_HI, 8'h80, `CSSB_RESP_OKAY);
        s_axi_wstrb <= 4'he;
        wr(`CSSB_IDX_SYS_HI, 8'h01, `CSSB_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        sys_m = 16'h0140;
        rd(`CSSB_IDX_SYS_LO);
        rd(`CSSB_IDX_SYS_HI);
        {go_cmd, clear_cmd, force_cmd} <= 3'h7;
        @(posedge aclk);
        {go_cmd, clear_cmd, force_cmd} <= 3'h0;
        pend_m = 3'h7;
        @(posedge aclk);
        rd(`CSSB_IDX_FALLBACK);
        frame_sync <= 1'b1;
        @(posedge aclk);
        frame_sync <= 1'b0;
        chk({29'h0, go_take, clear_take, force_take}, 32'h7);
        pend_m = 3'h0;
        @(posedge aclk);
        rd(`CSSB_IDX_FALLBACK);
        // a go that arrives with the frame must wait for the next one
        {go_cmd, clear_cmd, force_cmd} <= 3'h7;
        @(posedge aclk);
        {go_cmd, clear_cmd, force_cmd, frame_sync} <= 4'h9;
        @(posedge aclk);
        {go_cmd, frame_sync} <= 2'h0;
        chk({29'h0, go_take, clear_take, force_take}, 32'h7);
        pend_m = 3'h4;
        @(posedge aclk);
        rd(`CSSB_IDX_FALLBACK);
        for (int k = 0; k < 2; k++) begin
            {vc_pause_cmd, vc_start_cmd} <= k[0] ? 2'h2 : 2'h1;
            @(posedge aclk);
            {vc_pause_cmd, vc_start_cmd} <= 2'h0;
            {pp_m, sp_m} = k[0] ? 2'h2 : 2'h1;
            @(posedge aclk);
            rd(`CSSB_IDX_VC);
            frame_sync <= 1'b1;
            @(posedge aclk);
            frame_sync <= 1'b0;
            {pp_m, sp_m} = 2'h0;
            vc_m = k[0] ? 4'h0 : 4'h1;
            @(posedge aclk);
            rd(`CSSB_IDX_VC);
            chk({28'h0, vc_switching_state}, {28'h0, vc_m});
        end
        vc_start_cmd <= 1'b1;
        @(posedge aclk);
        vc_start_cmd <= 1'b0;
        frame_sync <= 1'b1;
        @(posedge aclk);
        frame_sync <= 1'b0;
        vc_m = 4'h1;
        @(posedge aclk);
        rd(`CSSB_IDX_VC);
        test_done();
    end
endmodule : cssb_status_bank_tb

`default_nettype wire
